// >>> logic/conv_cfg_pkg.sv
// package for the converter configuration and sync register bank
// assumes one 25 MHz clock and a byte-wide serial register port in front
package conv_cfg_pkg;
    // ***********************************
    // register addresses and resets
    // ***********************************
    localparam int ADDR_W = 15;
    localparam logic [ADDR_W-1:0] OFS_CONFIG_A = 15'h0000;
    localparam logic [ADDR_W-1:0] OFS_DEVICE_OPERATING_CONFIG = 15'h0002;
    localparam logic [ADDR_W-1:0] OFS_MANUFACTURER_CODE_LO = 15'h000C;
    localparam logic [ADDR_W-1:0] OFS_MANUFACTURER_CODE_HI = 15'h000D;
    localparam logic [ADDR_W-1:0] OFS_USER_SERIAL_CONFIG = 15'h0010;
    localparam logic [ADDR_W-1:0] OFS_SYNC_REFERENCE_CONTROL = 15'h0029;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_INPUT_CONFIG = 15'h002A;
    localparam logic [7:0] RST_CONFIG_A = 8'h30;
    localparam logic [7:0] RST_DEVICE_OPERATING_CONFIG = 8'h00;
    localparam logic [7:0] RST_USER_SERIAL_CONFIG = 8'h00;
    localparam logic [7:0] RST_SYNC_REFERENCE_CONTROL = 8'h80;
    localparam logic [7:0] RST_CLOCK_INPUT_CONFIG = 8'h00;
    // arbitrary neutral identity value
    localparam logic [15:0] MANUFACTURER_CODE_VALUE = 16'h5A5A;
    // ***********************************
    // field positions
    // ***********************************
    localparam int BIT_ADDR_UP = 5;
    localparam int BIT_SDO_ACTIVE = 4;
    localparam int BIT_ADDR_HOLD = 0;
    localparam int BIT_PROC_EN = 6;
    localparam int BIT_RECV_EN = 5;
    localparam int BIT_ZOOM = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 0;
    localparam int BIT_CLK_PECL = 2;
    localparam int BIT_SYNC_PECL = 1;
    localparam int BIT_INVERT = 0;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ***********************************
    // types
    // ***********************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STREAM = 3'b010,
        ST_DONE = 3'b100
    } access_state_t;
    // one byte access from the serial front end
    typedef struct packed {
        logic start;
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } reg_req_t;
    // controls handed to the analog and sync logic
    typedef struct packed {
        logic power_down;
        logic sync_receiver_enable;
        logic sync_processor_enable;
        logic fine_window_scale;
        logic [3:0] sync_delay_select;
        logic sample_clock_pecl_input;
        logic sync_pecl_input;
        logic sync_polarity_invert;
    } conv_ctrl_t;
endpackage

// >>> logic/conv_cfg_regs.sv
// converter configuration and sync register bank
// assumes a serial front end that hands over one byte access per valid pulse,
// with start marking the first byte of a streaming transfer
module conv_cfg_regs (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // register access
    input wire conv_cfg_pkg::reg_req_t req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic [conv_cfg_pkg::ADDR_W-1:0] cur_addr_out,
    // sync input and analog controls
    input wire logic sync_in,
    output conv_cfg_pkg::conv_ctrl_t ctrl_out,
    output logic clk_self_bias_out,
    output logic sync_self_bias_out,
    output logic sync_event_out,
    output logic [3:0] sync_tap_out
);
    import conv_cfg_pkg::*;

    // ***********************************
    // registers
    // ***********************************
    logic [7:0] config_a_r;
    logic [7:0] device_operating_config_r;
    logic [7:0] user_serial_config_r;
    logic [7:0] sync_reference_control_r;
    logic [7:0] clock_input_config_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    access_state_t state_r;
    access_state_t state_nxt;
    logic [7:0] rdata_r;
    logic rvalid_r;
    conv_ctrl_t ctrl_r;
    logic clk_bias_r;
    logic sync_bias_r;
    conv_ctrl_t ctrl_nxt;
    logic [ADDR_W-1:0] acc_addr;
    logic [7:0] rd_mux;
    logic wr;
    logic [15:0] manufacturer_code_field;
    logic wr_config_a;
    logic wr_device_operating_config;
    logic wr_user_serial_config;
    logic wr_sync_reference_control;
    logic wr_clock_input_config;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // ***********************************
    // streaming address
    // ***********************************
    // the first byte of a transfer uses the host address, later bytes our counter
    assign acc_addr = req_in.start ? req_in.addr : addr_r;
    // fixed address when hold is set, else step by direction
    assign addr_nxt = user_serial_config_r[BIT_ADDR_HOLD] ? acc_addr :
        (config_a_r[BIT_ADDR_UP] ? acc_addr + 15'h0001 : acc_addr - 15'h0001);
    assign wr = req_in.valid & req_in.write;
    // power down never gates the port, so the host can always wake the part
    assign manufacturer_code_field = MANUFACTURER_CODE_VALUE;

    // ***********************************
    // write decode
    // ***********************************
    // the code bytes and unmapped addresses have no strobe, so writes there vanish
    assign wr_config_a = wr & hit(acc_addr, OFS_CONFIG_A);
    assign wr_device_operating_config = wr & hit(acc_addr, OFS_DEVICE_OPERATING_CONFIG);
    assign wr_user_serial_config = wr & hit(acc_addr, OFS_USER_SERIAL_CONFIG);
    assign wr_sync_reference_control = wr & hit(acc_addr, OFS_SYNC_REFERENCE_CONTROL);
    assign wr_clock_input_config = wr & hit(acc_addr, OFS_CLOCK_INPUT_CONFIG);

    // ***********************************
    // read path
    // ***********************************
    // unmapped addresses read as zero, so a host scanning the map sees no stale bytes
    assign rd_mux =
        hit(acc_addr, OFS_CONFIG_A) ? config_a_r :
        hit(acc_addr, OFS_DEVICE_OPERATING_CONFIG) ? device_operating_config_r :
        hit(acc_addr, OFS_MANUFACTURER_CODE_LO) ? manufacturer_code_field[7:0] :
        hit(acc_addr, OFS_MANUFACTURER_CODE_HI) ? manufacturer_code_field[15:8] :
        hit(acc_addr, OFS_USER_SERIAL_CONFIG) ? user_serial_config_r :
        hit(acc_addr, OFS_SYNC_REFERENCE_CONTROL) ? sync_reference_control_r :
        hit(acc_addr, OFS_CLOCK_INPUT_CONFIG) ? clock_input_config_r : READ_UNMAPPED;

    // ***********************************
    // access state
    // ***********************************
    // frames each streaming transfer from its first byte to the idle gap after it
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (req_in.valid) begin
                    state_nxt = ST_STREAM;
                end
            end
            ST_STREAM: begin
                if (!req_in.valid) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = req_in.valid ? ST_STREAM : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ***********************************
    // controls to the analog side
    // ***********************************
    // modes 1 and 2 are reserved and behave as normal operation
    assign ctrl_nxt.power_down =
        (device_operating_config_r[MODE_HI:MODE_LO] == MODE_POWER_DOWN);
    assign ctrl_nxt.sync_receiver_enable = sync_reference_control_r[BIT_RECV_EN];
    assign ctrl_nxt.sync_processor_enable = sync_reference_control_r[BIT_PROC_EN];
    assign ctrl_nxt.fine_window_scale = sync_reference_control_r[BIT_ZOOM];
    assign ctrl_nxt.sync_delay_select = sync_reference_control_r[SEL_HI:SEL_LO];
    assign ctrl_nxt.sample_clock_pecl_input = clock_input_config_r[BIT_CLK_PECL];
    assign ctrl_nxt.sync_pecl_input = clock_input_config_r[BIT_SYNC_PECL];
    assign ctrl_nxt.sync_polarity_invert = clock_input_config_r[BIT_INVERT];

    // ***********************************
    // register storage
    // ***********************************
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            config_a_r <= RST_CONFIG_A;
            device_operating_config_r <= RST_DEVICE_OPERATING_CONFIG;
            user_serial_config_r <= RST_USER_SERIAL_CONFIG;
            sync_reference_control_r <= RST_SYNC_REFERENCE_CONTROL;
            clock_input_config_r <= RST_CLOCK_INPUT_CONFIG;
        end else if (enable_in) begin
            if (wr_config_a) begin
                config_a_r <= req_in.data | (8'h01 << BIT_SDO_ACTIVE);
            end
            if (wr_device_operating_config) begin
                device_operating_config_r <= req_in.data;
            end
            if (wr_user_serial_config) begin
                user_serial_config_r <= req_in.data;
            end
            if (wr_sync_reference_control) begin
                sync_reference_control_r <= req_in.data;
            end
            if (wr_clock_input_config) begin
                clock_input_config_r <= req_in.data;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_r <= '0;
            state_r <= ST_IDLE;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (enable_in) begin
            state_r <= state_nxt;
            rvalid_r <= req_in.valid & ~req_in.write;
            if (req_in.valid) begin
                addr_r <= addr_nxt;
                rdata_r <= req_in.write ? 8'h00 : rd_mux;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= '0;
            clk_bias_r <= 1'b1;
            sync_bias_r <= 1'b1;
        end else if (enable_in) begin
            ctrl_r <= ctrl_nxt;
            clk_bias_r <= ~ctrl_nxt.sample_clock_pecl_input;
            sync_bias_r <= ~ctrl_nxt.sync_pecl_input;
        end
    end

    // ***********************************
    // sync capture
    // ***********************************
    // fed from the registered controls: a new setting acts one edge after ctrl_out shows it
    sync_capture u_sync_capture (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .enable_in(enable_in),
        .ctrl_in(ctrl_r),
        .sync_in(sync_in),
        .sync_event_out(sync_event_out),
        .sync_tap_out(sync_tap_out)
    );

    // ***********************************
    // outputs
    // ***********************************
    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;
    assign cur_addr_out = addr_r;
    assign ctrl_out = ctrl_r;
    assign clk_self_bias_out = clk_bias_r;
    assign sync_self_bias_out = sync_bias_r;
endmodule

// >>> logic/sync_capture.sv
// sync event capture path: invert, delay select, processor gating
// assumes the sync input is already synchronous to clock_in
module sync_capture (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // controls
    input wire conv_cfg_pkg::conv_ctrl_t ctrl_in,
    // sync input and result
    input wire logic sync_in,
    output logic sync_event_out,
    output logic [3:0] sync_tap_out
);
    import conv_cfg_pkg::*;
    logic [15:0] delay_line_r;
    logic sync_rx;
    logic sync_sel;
    logic prev_r;
    logic event_r;
    logic [3:0] tap_r;
    // receiver off gives a quiet line; inversion before any use
    assign sync_rx = ctrl_in.sync_receiver_enable & ~ctrl_in.power_down
        & (sync_in ^ ctrl_in.sync_polarity_invert);
    // zoom halves the tap spacing: fine taps, coarse taps step by two
    assign sync_sel = ctrl_in.fine_window_scale ?
        delay_line_r[ctrl_in.sync_delay_select] :
        delay_line_r[{ctrl_in.sync_delay_select[2:0], 1'b0}];
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            delay_line_r <= 16'h0000;
            prev_r <= 1'b0;
            event_r <= 1'b0;
            tap_r <= 4'h0;
        end else if (enable_in) begin
            delay_line_r <= {delay_line_r[14:0], sync_rx};
            prev_r <= sync_sel;
            event_r <= sync_sel & ~prev_r & ctrl_in.sync_processor_enable;
            tap_r <= ctrl_in.sync_delay_select;
        end
    end
    assign sync_event_out = event_r;
    assign sync_tap_out = tap_r;
endmodule

// >>> tb/conv_cfg_regs_monitor.sv
// concurrent checks on the register bank ports
// assumes it is bound onto conv_cfg_regs with enable_in held high
module conv_cfg_monitor (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    // register access
    input wire conv_cfg_pkg::reg_req_t req_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic [conv_cfg_pkg::ADDR_W-1:0] cur_addr_out,
    // sync and controls
    input wire logic sync_in,
    input wire conv_cfg_pkg::conv_ctrl_t ctrl_out,
    input wire logic clk_self_bias_out,
    input wire logic sync_self_bias_out,
    input wire logic sync_event_out,
    input wire logic [3:0] sync_tap_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import conv_cfg_pkg::*;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    wire logic take = enable_in && req_in.valid;
    wire logic rd = take && !req_in.write;
    wire logic wr = take && req_in.write && req_in.start;
    // only a start byte carries an address; later bytes use the stream pointer
    wire logic [ADDR_W-1:0] base = req_in.start ? req_in.addr : cur_addr_out;
    // ***********************************
    // assertions
    // ***********************************
    a_mode_power: assert property (wr && req_in.addr == OFS_DEVICE_OPERATING_CONFIG
        |-> ##2 ctrl_out.power_down == ($past(req_in.data[1:0], 2) == MODE_POWER_DOWN))
        else $error("power down not set by mode");
    a_code_fixed: assert property (
        rd && (base == OFS_MANUFACTURER_CODE_LO || base == OFS_MANUFACTURER_CODE_HI)
        |=> rdata_out == ($past(base[0]) ? MANUFACTURER_CODE_VALUE[15:8]
        : MANUFACTURER_CODE_VALUE[7:0])) else $error("manufacturer code wrong");
    a_stream_step: assert property (take |=> cur_addr_out == $past(base)
        || cur_addr_out == $past(base) + 15'h0001 || cur_addr_out == $past(base) - 15'h0001)
        else $error("stream address jumped");
    a_addr_still: assert property (!take |=> $stable(cur_addr_out))
        else $error("stream address moved without access");
    a_sync_fields: assert property (wr && req_in.addr == OFS_SYNC_REFERENCE_CONTROL
        |-> ##2 {ctrl_out.sync_processor_enable, ctrl_out.sync_receiver_enable,
        ctrl_out.fine_window_scale, ctrl_out.sync_delay_select} == $past(req_in.data[6:0], 2))
        else $error("sync controls not taken");
    a_input_fields: assert property (wr && req_in.addr == OFS_CLOCK_INPUT_CONFIG
        |-> ##2 {ctrl_out.sample_clock_pecl_input, ctrl_out.sync_pecl_input,
        ctrl_out.sync_polarity_invert} == $past(req_in.data[2:0], 2))
        else $error("input controls not taken");
    a_bias_off: assert property ({clk_self_bias_out, sync_self_bias_out} ==
        ~{ctrl_out.sample_clock_pecl_input, ctrl_out.sync_pecl_input})
        else $error("self bias not tied to pecl mode");
    a_event_gate: assert property (sync_event_out |-> ctrl_out.sync_processor_enable
        || $past(ctrl_out.sync_processor_enable) || $past(ctrl_out.sync_processor_enable, 2))
        else $error("sync event without processor");
    a_read_live: assert property (rd && ctrl_out.power_down |=> rvalid_out)
        else $error("no read answer in power down");
endmodule

// >>> tb/converter_config_sync_regs_tb.sv
// self-checking bench for the converter register bank
// assumes the host model drives every access and enable_in stays high
module converter_config_sync_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import conv_cfg_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic sync_in = 1'b0;
    reg_req_t req;
    logic [7:0] rdata_out, v;
    logic rvalid_out, clk_self_bias_out, sync_self_bias_out, sync_event_out;
    logic [ADDR_W-1:0] cur_addr_out;
    logic [3:0] sync_tap_out;
    conv_ctrl_t ctrl_out;
    wire logic [4:0] cfg_seen = {ctrl_out.sample_clock_pecl_input, ctrl_out.sync_pecl_input,
        ctrl_out.sync_polarity_invert, clk_self_bias_out, sync_self_bias_out};
    logic [7:0] q[$];
    int miscompares = 0;
    int checks_done = 0;
    int seed = 15;
    int lat, lat0;
    always #20 clock_in = ~clock_in;
    reg_host_model host (.clock_in(clock_in), .req_out(req));
    conv_cfg_regs dut (.clock_in, .resetn_in, .enable_in(1'b1), .req_in(req), .rdata_out,
        .rvalid_out, .cur_addr_out, .sync_in, .ctrl_out, .clk_self_bias_out,
        .sync_self_bias_out, .sync_event_out, .sync_tap_out);
    // ***********************************
    // checking and helpers
    // ***********************************
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rd(input logic st, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        q.push_back(e);
        host.op(st, 1'b0, a, 8'h00);
    endtask
    // cycles from a sync step to lvl until the event pulse, 0 if none
    task automatic pulse(input logic lvl, output int n);
        @(posedge clock_in);
        #1 sync_in = ~lvl;
        repeat (20) @(posedge clock_in);
        #1 sync_in = lvl;
        n = 0;
        for (int i = 1; i <= 40 && n == 0; i++) begin
            @(posedge clock_in);
            if (sync_event_out === 1'b1) n = i;
        end
    endtask
    always @(posedge clock_in) begin
        if (rvalid_out === 1'b1 && q.size() == 0) check("spare read", 16'h0001, 16'h0000);
        else if (rvalid_out === 1'b1) check("read", 16'(rdata_out), 16'(q.pop_front()));
    end
    // tests need about 360 cycles; the limit of 5000 cycles allows about fourteen times that
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clock_in);
        #1 resetn_in = 1'b1;
        check("bias reset", 16'(cfg_seen), 16'h0003);
        rd(1'b1, OFS_DEVICE_OPERATING_CONFIG, RST_DEVICE_OPERATING_CONFIG);
        rd(1'b1, OFS_USER_SERIAL_CONFIG, RST_USER_SERIAL_CONFIG);
        rd(1'b1, OFS_SYNC_REFERENCE_CONTROL, RST_SYNC_REFERENCE_CONTROL);
        rd(1'b1, OFS_CLOCK_INPUT_CONFIG, RST_CLOCK_INPUT_CONFIG);
        rd(1'b1, 15'h0003, READ_UNMAPPED);
        v = 8'($random(seed));
        host.wr(OFS_MANUFACTURER_CODE_LO, v);
        host.wr(OFS_MANUFACTURER_CODE_HI, ~v);
        rd(1'b1, OFS_MANUFACTURER_CODE_LO, MANUFACTURER_CODE_VALUE[7:0]);
        rd(1'b0, '0, MANUFACTURER_CODE_VALUE[15:8]);
        check("up", 16'(cur_addr_out), 16'(OFS_MANUFACTURER_CODE_HI + 15'h0001));
        host.wr(OFS_CONFIG_A, 8'h00);
        rd(1'b1, OFS_MANUFACTURER_CODE_HI, MANUFACTURER_CODE_VALUE[15:8]);
        rd(1'b0, '0, MANUFACTURER_CODE_VALUE[7:0]);
        check("down", 16'(cur_addr_out), 16'(OFS_MANUFACTURER_CODE_LO - 15'h0001));
        host.wr(OFS_USER_SERIAL_CONFIG, 8'h01);
        rd(1'b1, OFS_MANUFACTURER_CODE_HI, MANUFACTURER_CODE_VALUE[15:8]);
        rd(1'b0, '0, MANUFACTURER_CODE_VALUE[15:8]);
        check("hold", 16'(cur_addr_out), 16'(OFS_MANUFACTURER_CODE_HI));
        host.wr(OFS_USER_SERIAL_CONFIG, 8'h00);
        host.wr(OFS_CONFIG_A, 8'h20);
        rd(1'b1, OFS_CONFIG_A, RST_CONFIG_A);
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & 8'h07;
            host.wr(OFS_CLOCK_INPUT_CONFIG, v);
            rd(1'b1, OFS_CLOCK_INPUT_CONFIG, v);
            check("input cfg", 16'(cfg_seen), 16'({v[2:0], ~v[2:1]}));
        end
        host.wr(OFS_CLOCK_INPUT_CONFIG, 8'h00);
        for (int m = 0; m < 4; m++) begin
            host.wr(OFS_DEVICE_OPERATING_CONFIG, 8'(m));
            rd(1'b1, OFS_DEVICE_OPERATING_CONFIG, 8'(m));
            check("power", 16'(ctrl_out.power_down), 16'(2'(m) == MODE_POWER_DOWN));
        end
        host.wr(OFS_DEVICE_OPERATING_CONFIG, 8'h00);
        rd(1'b1, OFS_DEVICE_OPERATING_CONFIG, 8'h00);
        pulse(1'b1, lat);
        check("sync off", 16'(lat), 16'h0000);
        host.wr(OFS_SYNC_REFERENCE_CONTROL, 8'h20);
        pulse(1'b1, lat);
        check("no processor", 16'(lat), 16'h0000);
        host.sync_on(1'b1, 4'h0);
        pulse(1'b1, lat0);
        check("event", 16'(lat0 > 0), 16'h0001);
        host.sync_on(1'b1, 4'h5);
        pulse(1'b1, lat);
        check("fine delay", 16'(lat - lat0), 16'h0005);
        check("tap", 16'(sync_tap_out), 16'h0005);
        host.sync_on(1'b0, 4'h5);
        pulse(1'b1, lat);
        check("coarse delay", 16'(lat - lat0), 16'h000A);
        host.wr(OFS_CLOCK_INPUT_CONFIG, 8'h01);
        pulse(1'b0, lat);
        check("inverted", 16'(lat - lat0), 16'h000A);
        repeat (3) @(posedge clock_in);
        check("reads left", 16'(q.size()), 16'h0000);
        end_sim();
    end
endmodule
bind conv_cfg_regs conv_cfg_monitor mon (.clock_in, .resetn_in, .enable_in, .req_in,
    .rdata_out, .rvalid_out, .cur_addr_out, .sync_in, .ctrl_out, .clk_self_bias_out,
    .sync_self_bias_out, .sync_event_out, .sync_tap_out);

// >>> tb/reg_host_model.sv
// host model: issues byte accesses into the register bank
// assumes the bench calls one task at a time
module reg_host_model (
    // clock
    input wire logic clock_in,
    // request toward the bank
    output conv_cfg_pkg::reg_req_t req_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import conv_cfg_pkg::*;
    // ***********************************
    // access tasks
    // ***********************************
    initial req_out = '0;
    task automatic op(input logic st, w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1 req_out = '{start: st, valid: 1'b1, write: w, addr: a, data: d};
        @(posedge clock_in);
        // idle lines keep moving so stale data is never taken for fresh
        #1 req_out = '{start: 1'b0, valid: 1'b0, write: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [15:0] mr;
        mr = a == OFS_CONFIG_A ? {8'h20, RST_CONFIG_A}
            : a == OFS_DEVICE_OPERATING_CONFIG ? {8'h03, RST_DEVICE_OPERATING_CONFIG}
            : a == OFS_USER_SERIAL_CONFIG ? {8'h01, RST_USER_SERIAL_CONFIG}
            : a == OFS_SYNC_REFERENCE_CONTROL ? {8'h7F, RST_SYNC_REFERENCE_CONTROL}
            : a == OFS_CLOCK_INPUT_CONFIG ? {8'h07, RST_CLOCK_INPUT_CONFIG} : 16'hFF00;
        op(1'b1, 1'b1, a, (d & mr[15:8]) | (mr[7:0] & ~mr[15:8]));
    endtask
    // receiver first, processor after; zoom and delay chosen by the caller
    task automatic sync_on(input logic z, input logic [3:0] s);
        wr(OFS_SYNC_REFERENCE_CONTROL, {3'b001, z, s});
        wr(OFS_SYNC_REFERENCE_CONTROL, {3'b011, z, s});
    endtask
endmodule
